//--- rtl/gmpc_pkg.sv
// Constants, field layouts and carrier types for the count overhead codec.
// Assumes one 10 MHz APB clock domain shared by encoder, decoder and bus.
package gmpc_pkg;

  localparam int CNT_W = 14;
  localparam int CNT10_W = 10;

  // APB byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CNT_MIN = 8'h04;
  localparam logic [7:0] ADDR_CNT_MAX = 8'h08;
  localparam logic [7:0] ADDR_SLOTS = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_TX_COUNT = 8'h14;
  localparam logic [7:0] ADDR_RX_COUNT = 8'h18;
  localparam logic [7:0] ADDR_CRC_ERRS = 8'h1c;
  localparam logic [7:0] ADDR_ENT_BITS = 8'h20;
  localparam logic [7:0] ADDR_REM_MAX = 8'h24;

  // Control register fields
  localparam int CTRL_C10_BIT = 0;
  localparam int CTRL_TWO_STATE_BIT = 1;
  localparam int CTRL_CLASS_LSB = 4;
  localparam int CTRL_CLASS_W = 3;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [13:0] CNT_MIN_RST = 14'h0000;
  localparam logic [13:0] CNT_MAX_RST = 14'h3fff;
  localparam logic [6:0] SLOTS_RST = 7'h01;

  // Inversion sets; bit 13 (bit 9 for 10-bit) is the first count bit (MSB), bit 0 the last
  localparam logic [13:0] INV14_P1 = 14'h2aaa;
  localparam logic [13:0] INV14_M1 = 14'h1555;
  localparam logic [13:0] INV14_P2 = 14'h1999;
  localparam logic [13:0] INV14_M2 = 14'h2666;
  localparam logic [13:0] INV10_P1 = 14'h02aa;
  localparam logic [13:0] INV10_M1 = 14'h0259;
  localparam logic [13:0] INV10_P2 = 14'h0165;
  localparam logic [13:0] INV10_M2 = 14'h0196;

  // Count bits that sit in the first control octet, and the full count width masks
  localparam logic [13:0] OCT1_BITS14 = 14'h3fc0;
  localparam logic [13:0] OCT1_BITS10 = 14'h03f0;
  localparam logic [13:0] WIDTH_MASK14 = 14'h3fff;
  localparam logic [13:0] WIDTH_MASK10 = 14'h03ff;

  // Check generators, top term implied
  localparam logic [7:0] CRC8_POLY = 8'h0d;
  localparam logic [5:0] CRC6_POLY = 6'h0d;

  // High-order multi-slot container
  localparam int ENTITY_BITS_PER_SLOT = 128;
  localparam logic [13:0] HO_ENTITY_CAPACITY = 14'd952;

  // Cumulative remainder upper bounds, per rate class
  localparam logic [9:0] REM_MAX_C0 = 10'd7;
  localparam logic [9:0] REM_MAX_C1 = 10'd15;
  localparam logic [9:0] REM_MAX_C2 = 10'd63;
  localparam logic [9:0] REM_MAX_C3 = 10'd255;
  localparam logic [9:0] REM_MAX_C4 = 10'd639;

  typedef struct packed {
    logic [7:0] oct1;
    logic [7:0] oct2;
    logic [7:0] oct3;
  } gmpc_jc_s;

  typedef enum logic [1:0] {
    GMPC_HUNT,
    GMPC_HUNT_STEP,
    GMPC_SYNC
  } gmpc_sink_e;

endpackage : gmpc_pkg

//--- rtl/gmpc_crc.sv
// Parallel remainder of msg * x^CRC_W modulo the generator, MSB first.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module gmpc_crc #(
  parameter int MSG_W = 16,
  parameter int CRC_W = 8,
  parameter logic [CRC_W-1:0] POLY = '0
) (
  input wire logic [MSG_W-1:0] msg,
  output logic [CRC_W-1:0] crc
);

  always_comb begin
    logic [CRC_W-1:0] r;
    logic fb;
    r = '0;
    fb = 1'b0;
    for (int i = MSG_W - 1; i >= 0; i--) begin
      fb = msg[i] ^ r[CRC_W-1];
      r = {r[CRC_W-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
    crc = r;
  end

endmodule : gmpc_crc

//--- rtl/gmpc_codec.sv
// Count overhead encoder and decoder with an APB register slave.
// Assumes frame strobes and control octets come from logic on pclk.
//
// Contract
// - Count travels in three control octets, 14-bit or 10-bit by container.
// - Step up by one or two: send previous count inverted, increment flag set.
// - Step down by one or two: send previous count inverted, decrement flag set.
// - Larger change: both flags set, new count sent plain.
// - Unchanged count: both flags cleared.
// - The updated count becomes the reference for the next frame.
// - 14-bit: CRC-8, x^8+x^3+x^2+1, over first two octets, into third.
// - CRC-8 is message times x^8 mod generator, x^7 term sent first.
// - Sink checks 14-bit count: whole 24 bits divide to zero remainder.
// - 10-bit: CRC-6, x^6+x^3+x^2+1, over bits three to eight.
// - CRC-6 message is the 12 bits, MSB first, x^5 term sent first.
// - Sink checks 10-bit count: whole 18 bits divide to zero remainder.
// - Equal flags with good check: adopt received count, become synchronised.
// - Unequal flags with good check: low bits and flags pick hunt state.
// - Six-state hunt uses the two lowest count bits and both flags.
// - Two-state hunt uses only the lowest count bit and both flags.
// - Next frame equal flags with good check: take received count directly.
// - Next frame unequal flags: find step, undo inversion, expect that change.
// - Sent count is held between client minimum and maximum.
// - High-order container: entity is 128 bits per slot, 952 per multiframe.
// - Remainder ranges 0-7, 0-15, 0-63, 0-255, 0-639 by rate class.
// - 14-bit inversion sets: odd, even, 2-3-6-7-10-11-14, 1-4-5-8-9-12-13.
// - 10-bit inversion sets for plus and minus one and two.
// - Bad check, no valid pattern in either octet: keep count, restart hunt.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
module gmpc_codec
  import gmpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enc_req,
  input wire logic [13:0] enc_count,
  output gmpc_jc_s tx_jc,
  output logic tx_valid,
  input wire logic rx_valid,
  input wire gmpc_jc_s rx_jc,
  output logic [13:0] rx_count,
  output logic rx_sync,
  output logic rx_update,
  output logic rx_crc_err
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] ctrl;
    logic [13:0] cnt_min;
    logic [13:0] cnt_max;
    logic [6:0] slots;
    logic [13:0] prev_count;
    gmpc_jc_s tx_jc;
    logic tx_valid;
    gmpc_sink_e sink_st;
    logic [13:0] rx_count;
    logic [1:0] hunt_lsb;
    logic hunt_inc;
    logic rx_sync;
    logic rx_update;
    logic rx_crc_err;
    logic [15:0] crc_errs;
  } gmpc_state_s;

  gmpc_state_s cur;
  gmpc_state_s next_cur;

  // Pattern index k: bit 0 set means decrement, bit 1 set means a step of two
  function automatic logic [13:0] inv_mask(input logic c10, input logic [1:0] k);
    logic [13:0] m;
    m = '0;
    unique case (k)
      2'd0: m = c10 ? INV10_P1 : INV14_P1;
      2'd1: m = c10 ? INV10_M1 : INV14_M1;
      2'd2: m = c10 ? INV10_P2 : INV14_P2;
      2'd3: m = c10 ? INV10_M2 : INV14_M2;
    endcase
    return m;
  endfunction : inv_mask

  function automatic logic [13:0] apply_step(input logic [13:0] c, input logic [1:0] k,
                                             input logic [13:0] wm);
    logic [13:0] d;
    d = k[1] ? 14'h0002 : 14'h0001;
    return (k[0] ? (c - d) : (c + d)) & wm;
  endfunction : apply_step

  // Frame i+1 candidate is consistent with the bits seen in frame i
  function automatic logic hunt_fits(input logic [13:0] cand, input logic inc0,
                                     input logic [1:0] lsb, input logic two,
                                     input logic c10, input logic [13:0] wm);
    logic hit;
    logic [1:0] k0;
    logic [13:0] seen;
    hit = 1'b0;
    k0 = '0;
    seen = '0;
    for (int j = 0; j < 2; j++) begin
      k0 = {j[0], ~inc0};
      seen = apply_step(cand, {j[0], inc0}, wm) ^ inv_mask(c10, k0);
      if (two ? (seen[0] == lsb[0]) : (seen[1:0] == lsb)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : hunt_fits

  logic c10;
  logic two_state;
  logic [13:0] wm;
  logic [13:0] oct1_bits;
  logic [13:0] lim_max;
  logic [13:0] tx_cnt;
  logic [13:0] tx_diff;
  logic [13:0] tx_bits;
  logic tx_ii;
  logic tx_di;
  logic [7:0] tx_o1;
  logic [7:0] tx_o2;
  logic [7:0] tx_crc8;
  logic [5:0] tx_crc6;
  logic [13:0] rc;
  logic rx_ii;
  logic rx_di;
  logic [7:0] rx_crc8;
  logic [5:0] rx_crc6;
  logic crc_ok;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [2:0] rclass;
  logic [9:0] rem_max;

  assign c10 = cur.ctrl[CTRL_C10_BIT];
  assign two_state = cur.ctrl[CTRL_TWO_STATE_BIT];
  assign wm = c10 ? WIDTH_MASK10 : WIDTH_MASK14;
  assign oct1_bits = c10 ? OCT1_BITS10 : OCT1_BITS14;
  assign rclass = cur.ctrl[CTRL_CLASS_LSB +: CTRL_CLASS_W];

  // Maximum is bounded by the configured limit and the container capacity
  assign lim_max = (cur.cnt_max > HO_ENTITY_CAPACITY) ? HO_ENTITY_CAPACITY
                                                       : cur.cnt_max;

  // Encoder: clamp, then choose the step code against the reference
  always_comb begin
    tx_cnt = enc_count & wm;
    if (tx_cnt < cur.cnt_min) begin
      tx_cnt = cur.cnt_min;
    end else if (tx_cnt > lim_max) begin
      tx_cnt = lim_max;
    end
    tx_diff = (tx_cnt - cur.prev_count) & wm;
    tx_bits = tx_cnt;
    tx_ii = 1'b1;
    tx_di = 1'b1;
    if (tx_diff == 14'h0000) begin
      tx_bits = cur.prev_count;
      tx_ii = 1'b0;
      tx_di = 1'b0;
    end else if (tx_diff == 14'h0001 || tx_diff == 14'h0002) begin
      tx_bits = cur.prev_count ^ inv_mask(c10, {tx_diff[1], 1'b0});
      tx_ii = 1'b1;
      tx_di = 1'b0;
    end else if (tx_diff == (wm & 14'h3fff) || tx_diff == (wm - 14'h0001)) begin
      tx_bits = cur.prev_count ^ inv_mask(c10, {~tx_diff[0], 1'b1});
      tx_ii = 1'b0;
      tx_di = 1'b1;
    end
    if (c10) begin
      tx_o1 = {2'b00, tx_bits[9:4]};
      tx_o2 = {2'b00, tx_bits[3:0], tx_ii, tx_di};
    end else begin
      tx_o1 = tx_bits[13:6];
      tx_o2 = {tx_bits[5:0], tx_ii, tx_di};
    end
  end

  gmpc_crc #(.MSG_W(16), .CRC_W(8), .POLY(CRC8_POLY)) u_tx_crc8 (
    .msg({tx_o1, tx_o2}),
    .crc(tx_crc8)
  );

  gmpc_crc #(.MSG_W(12), .CRC_W(6), .POLY(CRC6_POLY)) u_tx_crc6 (
    .msg({tx_o1[5:0], tx_o2[5:0]}),
    .crc(tx_crc6)
  );

  // Receive side unpack and check
  assign rc = c10 ? {4'h0, rx_jc.oct1[5:0], rx_jc.oct2[5:2]} : {rx_jc.oct1, rx_jc.oct2[7:2]};
  assign rx_ii = rx_jc.oct2[1];
  assign rx_di = rx_jc.oct2[0];

  gmpc_crc #(.MSG_W(16), .CRC_W(8), .POLY(CRC8_POLY)) u_rx_crc8 (
    .msg({rx_jc.oct1, rx_jc.oct2}),
    .crc(rx_crc8)
  );

  gmpc_crc #(.MSG_W(12), .CRC_W(6), .POLY(CRC6_POLY)) u_rx_crc6 (
    .msg({rx_jc.oct1[5:0], rx_jc.oct2[5:0]}),
    .crc(rx_crc6)
  );

  // Matching the recomputed check equals a zero remainder over all bits
  assign crc_ok = c10 ? (rx_crc6 == rx_jc.oct3[5:0])
                      : (rx_crc8 == rx_jc.oct3);

  always_comb begin
    unique case (rclass)
      3'd0: rem_max = REM_MAX_C0;
      3'd1: rem_max = REM_MAX_C1;
      3'd2: rem_max = REM_MAX_C2;
      3'd3: rem_max = REM_MAX_C3;
      3'd4: rem_max = REM_MAX_C4;
      default: rem_max = '0;
    endcase
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = '0;
    unique case (paddr)
      ADDR_CTRL: rd_val = {24'h000000, cur.ctrl};
      ADDR_CNT_MIN: rd_val = {18'h00000, cur.cnt_min};
      ADDR_CNT_MAX: rd_val = {18'h00000, cur.cnt_max};
      ADDR_SLOTS: rd_val = {25'h0000000, cur.slots};
      ADDR_STATUS: rd_val = {30'h00000000, cur.sink_st != GMPC_HUNT, cur.rx_sync};
      ADDR_TX_COUNT: rd_val = {18'h00000, cur.prev_count};
      ADDR_RX_COUNT: rd_val = {18'h00000, cur.rx_count};
      ADDR_CRC_ERRS: rd_val = {16'h0000, cur.crc_errs};
      ADDR_ENT_BITS: rd_val = 32'(ENTITY_BITS_PER_SLOT) * {25'h0000000, cur.slots};
      ADDR_REM_MAX: rd_val = {22'h000000, rem_max};
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    logic [13:0] diff;
    logic [13:0] cand;
    logic [3:0] m1;
    logic [3:0] m2;
    logic [1:0] k1;
    logic [1:0] k2;
    logic [1:0] kc;
    logic [1:0] nfit;
    logic wr;
    diff = '0;
    cand = '0;
    m1 = '0;
    m2 = '0;
    k1 = '0;
    k2 = '0;
    kc = '0;
    nfit = '0;
    next_cur = cur;
    next_cur.tx_valid = 1'b0;
    next_cur.rx_update = 1'b0;
    next_cur.rx_crc_err = 1'b0;

    // APB: ready rises in the first access cycle, zero wait states
    next_cur.pready = psel & ~penable & ~cur.pready;
    if (psel && !penable) begin
      next_cur.prdata = pwrite ? 32'h00000000 : rd_val;
      next_cur.pslverr = ~rd_hit;
    end
    wr = psel & penable & cur.pready & pwrite;
    if (wr && paddr == ADDR_CTRL) begin
      next_cur.ctrl = pwdata[7:0];
    end
    if (wr && paddr == ADDR_CNT_MIN) begin
      next_cur.cnt_min = pwdata[13:0];
    end
    if (wr && paddr == ADDR_CNT_MAX) begin
      next_cur.cnt_max = pwdata[13:0];
    end
    if (wr && paddr == ADDR_SLOTS) begin
      next_cur.slots = pwdata[6:0];
    end

    if (enc_req) begin
      next_cur.tx_jc.oct1 = tx_o1;
      next_cur.tx_jc.oct2 = tx_o2;
      next_cur.tx_jc.oct3 = c10 ? {2'b00, tx_crc6} : tx_crc8;
      next_cur.tx_valid = 1'b1;
      next_cur.prev_count = tx_cnt;
    end

    if (rx_valid) begin
      diff = (rc ^ cur.rx_count) & wm;
      for (int k = 0; k < 4; k++) begin
        m1[k] = ((diff ^ inv_mask(c10, 2'(k))) & oct1_bits) == 14'h0000;
        m2[k] = ((diff ^ inv_mask(c10, 2'(k))) & wm & ~oct1_bits) == 14'h0000
                && rx_ii == ~k[0] && rx_di == k[0];
      end
      for (int k = 3; k >= 0; k--) begin
        if (m1[k]) begin
          k1 = 2'(k);
        end
        if (m2[k]) begin
          k2 = 2'(k);
        end
      end
      if (!crc_ok && next_cur.crc_errs != 16'hffff) begin
        next_cur.crc_errs = cur.crc_errs + 16'h0001;
      end
      next_cur.rx_crc_err = ~crc_ok;

      if (crc_ok && rx_ii == rx_di) begin
        next_cur.rx_count = rc;
        next_cur.rx_sync = 1'b1;
        next_cur.rx_update = 1'b1;
        next_cur.sink_st = GMPC_SYNC;
      end else if (crc_ok) begin
        if (cur.sink_st == GMPC_SYNC && (m1 & m2) != 4'h0) begin
          next_cur.rx_count = apply_step(cur.rx_count, k2, wm);
          next_cur.rx_update = 1'b1;
        end else if (cur.sink_st == GMPC_HUNT_STEP) begin
          // Try both step sizes in the signalled direction
          for (int j = 0; j < 2; j++) begin
            cand = (rc ^ inv_mask(c10, {j[0], rx_di})) & wm;
            if (hunt_fits(cand, cur.hunt_inc, cur.hunt_lsb, two_state, c10, wm)) begin
              kc = {j[0], rx_di};
              nfit = nfit + 2'd1;
            end
          end
          if (nfit == 2'd1) begin
            cand = (rc ^ inv_mask(c10, kc)) & wm;
            next_cur.rx_count = apply_step(cand, kc, wm);
            next_cur.rx_sync = 1'b1;
            next_cur.rx_update = 1'b1;
            next_cur.sink_st = GMPC_SYNC;
          end else begin
            next_cur.hunt_lsb = rc[1:0];
            next_cur.hunt_inc = rx_ii;
          end
        end else begin
          next_cur.rx_sync = 1'b0;
          next_cur.hunt_lsb = two_state ? {1'b0, rc[0]} : rc[1:0];
          next_cur.hunt_inc = rx_ii;
          next_cur.sink_st = GMPC_HUNT_STEP;
        end
      end else if (cur.sink_st == GMPC_SYNC) begin
        if (m1 != 4'h0 && m2 != 4'h0) begin
          if (k1 == k2) begin
            next_cur.rx_count = apply_step(cur.rx_count, k1, wm);
            next_cur.rx_update = 1'b1;
          end else begin
            next_cur.rx_sync = 1'b0;
            next_cur.sink_st = GMPC_HUNT;
          end
        end else if (m1 != 4'h0 || m2 != 4'h0) begin
          next_cur.rx_count = apply_step(cur.rx_count, (m1 != 4'h0) ? k1 : k2, wm);
          next_cur.rx_update = 1'b1;
        end else begin
          next_cur.rx_sync = 1'b0;
          next_cur.sink_st = GMPC_HUNT;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      cur.ctrl <= CTRL_RST;
      cur.cnt_min <= CNT_MIN_RST;
      cur.cnt_max <= CNT_MAX_RST;
      cur.slots <= SLOTS_RST;
      cur.sink_st <= GMPC_HUNT;
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign tx_jc = cur.tx_jc;
  assign tx_valid = cur.tx_valid;
  assign rx_count = cur.rx_count;
  assign rx_sync = cur.rx_sync;
  assign rx_update = cur.rx_update;
  assign rx_crc_err = cur.rx_crc_err;

endmodule : gmpc_codec

//--- testbench/gmpc_peer.sv
// Peer source model: encodes counts into control octets towards the sink.
// Assumes the codec sink runs in 14-bit mode on the same pclk.
`timescale 1ns/1ps
module gmpc_peer
  import gmpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send,
  input wire logic load,
  input wire logic corrupt,
  input wire logic [13:0] count,
  output logic rx_valid,
  output gmpc_jc_s rx_jc
);
  logic [13:0] ref_cnt;

  function automatic logic [7:0] crc(input logic [15:0] m, input bit c10);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      if (!c10 || i < 12) begin
        r = {r[6:0], 1'b0} ^ ((((c10 ? r[5] : r[7]) ^ m[i]) == 1'b1) ? 8'h0d : 8'h00);
      end
    end
    return c10 ? (r & 8'h3f) : r;
  endfunction : crc

  function automatic gmpc_jc_s encode(input logic [13:0] p, input logic [13:0] c, input bit c10);
    gmpc_jc_s j;
    logic [13:0] v;
    logic [1:0] f;
    f = 2'b10;
    if (c == p + 14'h1) v = p ^ (c10 ? INV10_P1 : INV14_P1);
    else if (c == p + 14'h2) v = p ^ (c10 ? INV10_P2 : INV14_P2);
    else begin
      f = 2'b01;
      if (c + 14'h1 == p) v = p ^ (c10 ? INV10_M1 : INV14_M1);
      else if (c + 14'h2 == p) v = p ^ (c10 ? INV10_M2 : INV14_M2);
      else begin
        v = c;
        f = (c == p) ? 2'b00 : 2'b11;
      end
    end
    if (c10) begin
      j.oct1 = {2'b00, v[9:4]};
      j.oct2 = {2'b00, v[3:0], f};
      j.oct3 = crc({4'h0, j.oct1[5:0], j.oct2[5:0]}, 1'b1);
    end else begin
      j.oct1 = v[13:6];
      j.oct2 = {v[5:0], f};
      j.oct3 = crc({j.oct1, j.oct2}, 1'b0);
    end
    return j;
  endfunction : encode

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt <= 14'h0000;
      rx_valid <= 1'b0;
      rx_jc <= '0;
    end else if (send) begin
      rx_jc <= encode(ref_cnt, count, 1'b0) ^ {16'h0000, corrupt ? 8'h5a : 8'h00};
      rx_valid <= 1'b1;
      ref_cnt <= count;
    end else begin
      if (load) ref_cnt <= count;
      rx_valid <= 1'b0;
      // Octets outside a frame do not keep their last value
      rx_jc <= ~rx_jc;
    end
  end
endmodule : gmpc_peer

//--- testbench/gmpc_codec_monitor.sv
// Concurrent checks on the count overhead codec ports.
// Assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/1ps
module gmpc_codec_monitor
  import gmpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic enc_req,
  input wire logic [13:0] enc_count,
  input wire gmpc_jc_s tx_jc,
  input wire logic tx_valid,
  input wire logic rx_valid,
  input wire gmpc_jc_s rx_jc,
  input wire logic [13:0] rx_count,
  input wire logic rx_sync,
  input wire logic rx_update,
  input wire logic rx_crc_err
);
  logic [13:0] last_cnt;

  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic logic [7:0] crc(input logic [15:0] m, input bit c10);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      if (!c10 || i < 12) begin
        r = {r[6:0], 1'b0} ^ ((((c10 ? r[5] : r[7]) ^ m[i]) == 1'b1) ? 8'h0d : 8'h00);
      end
    end
    return c10 ? (r & 8'h3f) : r;
  endfunction : crc

  // True when either check form passes
  function automatic logic good(input gmpc_jc_s j);
    return (crc({j.oct1, j.oct2}, 1'b0) == j.oct3) ||
      (crc({4'h0, j.oct1[5:0], j.oct2[5:0]}, 1'b1) == {2'b00, j.oct3[5:0]});
  endfunction : good

  always_ff @(posedge pclk) last_cnt <= {rx_jc.oct1, rx_jc.oct2[7:2]};

  a_tx_latency: assert property (enc_req |=> tx_valid)
    else $error("no encoded frame after a request");
  a_tx_quiet: assert property (!enc_req |=> !tx_valid && $stable(tx_jc))
    else $error("encoder output moved without a request");
  a_tx_check: assert property (tx_valid |-> good(tx_jc))
    else $error("encoded frame carries a bad check");
  a_upd_cause: assert property (rx_update |-> $past(rx_valid))
    else $error("count update without a received frame");
  a_err_cause: assert property (rx_crc_err |-> $past(rx_valid))
    else $error("check error without a received frame");
  a_rx_hold: assert property (!rx_valid |=> $stable(rx_count) && $stable(rx_sync) && !rx_update)
    else $error("sink state moved without a frame");
  a_upd_synced: assert property (rx_update |-> rx_sync)
    else $error("count released while unsynchronised");
  a_bad_check: assert property (rx_valid && !good(rx_jc) |=> rx_crc_err)
    else $error("bad check not flagged");
  a_rx_adopt: assert property (rx_valid && rx_jc.oct1[7:6] != 2'b00 &&
      rx_jc.oct2[1] == rx_jc.oct2[0] && crc({rx_jc.oct1, rx_jc.oct2}, 1'b0) == rx_jc.oct3
      |=> rx_sync && rx_count == last_cnt)
    else $error("plain count not adopted");

  c_full: cover property (tx_valid && tx_jc.oct2[1:0] == 2'b11);
  c_sync: cover property ($rose(rx_sync));
  c_err: cover property (rx_crc_err);
endmodule : gmpc_codec_monitor

bind gmpc_codec gmpc_codec_monitor gmpc_codec_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .enc_req(enc_req), .enc_count(enc_count), .tx_jc(tx_jc), .tx_valid(tx_valid),
  .rx_valid(rx_valid), .rx_jc(rx_jc), .rx_count(rx_count), .rx_sync(rx_sync),
  .rx_update(rx_update), .rx_crc_err(rx_crc_err)
);

//--- testbench/tb_gmpc_codec.sv
// Self-checking bench for the count overhead codec with a peer source.
// Assumes the codec, its package and the peer model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t got %h expected %h", $time, g, e); end end
module tb_gmpc_codec
  import gmpc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, enc_req = 1'b0;
  logic send = 1'b0, load = 1'b0, corrupt = 1'b0, c10 = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [13:0] enc_count = 14'h0, pcount = 14'h0, tx_ref = 14'h0, lo = 14'h0, hi = 14'd952;
  logic pready, pslverr, tx_valid, rx_valid, rx_sync, rx_update, rx_crc_err;
  logic [13:0] rx_count;
  gmpc_jc_s tx_jc, rx_jc;
  gmpc_jc_s exp_tx[$];
  logic [32:0] exp_rd[$];
  logic [15:0] exp_rx[$];
  int mismatches = 0, num_checks = 0, seed = 81680, cyc = 0;
  int d[8] = '{0, 1, -1, 2, -2, 3, -3, 100};
  logic [31:0] rem[6] = '{32'h7, 32'hf, 32'h3f, 32'hff, 32'h27f, 32'h0};
  logic [7:0] ra[8] = '{ADDR_CTRL, ADDR_CNT_MIN, ADDR_CNT_MAX, ADDR_SLOTS, ADDR_ENT_BITS,
    ADDR_STATUS, ADDR_RX_COUNT, 8'h28};
  logic [32:0] rv[8] = '{33'h0, 33'h0, 33'h3fff, 33'h1, 33'h80, 33'h3, 33'h1388, 33'h100000000};
  logic [13:0] seq[4] = '{14'd501, 14'd502, 14'd500, 14'd5000};

  always #50 pclk = ~pclk;

  gmpc_codec gmpc_codec_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enc_req(enc_req), .enc_count(enc_count), .tx_jc(tx_jc), .tx_valid(tx_valid),
    .rx_valid(rx_valid), .rx_jc(rx_jc), .rx_count(rx_count), .rx_sync(rx_sync),
    .rx_update(rx_update), .rx_crc_err(rx_crc_err)
  );

  gmpc_peer gmpc_peer_i (
    .pclk(pclk), .presetn(presetn), .send(send), .load(load), .corrupt(corrupt),
    .count(pcount), .rx_valid(rx_valid), .rx_jc(rx_jc)
  );

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // Result watcher; the timeout sits far above the under two hundred cycles used
  always @(posedge pclk) begin
    cyc++;
    if (tx_valid === 1'b1) `CHK(tx_jc, exp_tx.pop_front())
    if (psel && penable && pready === 1'b1 && !pwrite) `CHK({pslverr, prdata}, exp_rd.pop_front())
    if (rx_update === 1'b1 || rx_crc_err === 1'b1) `CHK({rx_crc_err, rx_sync, rx_count}, exp_rx.pop_front())
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [32:0] e);
    int n;
    n = 0;
    if (!w) exp_rd.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic enc(input logic [13:0] c);
    logic [13:0] k;
    k = (c < lo) ? lo : ((c > hi) ? hi : c);
    exp_tx.push_back(gmpc_peer_i.encode(tx_ref, k, c10));
    tx_ref = k;
    enc_req <= 1'b1;
    enc_count <= c;
    @(posedge pclk);
  endtask : enc

  task automatic tx_run;
    logic [31:0] r;
    enc(14'd500);
    for (int i = 0; i < 32; i++) begin
      r = $random(seed);
      enc((i % 3 == 2) ? 14'(r[9:0]) : tx_ref + 14'(d[i % 8]));
    end
    enc_req <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : tx_run

  task automatic frame(input logic s, input logic [13:0] c, input logic bad);
    send <= s;
    load <= !s;
    corrupt <= bad;
    pcount <= c;
    @(posedge pclk);
    send <= 1'b0;
    load <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : frame

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    frame(1'b0, 14'd500, 1'b0);
    exp_rx.push_back({2'b10, 14'h0});
    frame(1'b1, 14'd500, 1'b1);
    frame(1'b1, 14'd501, 1'b0);
    `CHK(rx_sync, 1'b0)
    foreach (seq[i]) begin
      exp_rx.push_back({2'b01, seq[i]});
      frame(1'b1, seq[i], 1'b0);
    end
    foreach (ra[i]) apb(1'b0, ra[i], 32'h0, rv[i]);
    apb(1'b1, ADDR_SLOTS, 32'h5, 33'h0);
    apb(1'b0, ADDR_ENT_BITS, 32'h0, 33'h280);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ADDR_CTRL, 32'(i) << 4, 33'h0);
      apb(1'b0, ADDR_REM_MAX, 32'h0, {1'b0, rem[i]});
    end
    apb(1'b1, ADDR_CTRL, 32'h0, 33'h0);
    tx_run();
    apb(1'b1, ADDR_TX_COUNT, 32'h1234, 33'h0);
    apb(1'b0, ADDR_TX_COUNT, 32'h0, {19'h0, tx_ref});
    apb(1'b1, ADDR_CNT_MIN, 32'h64, 33'h0);
    apb(1'b1, ADDR_CNT_MAX, 32'h258, 33'h0);
    apb(1'b1, ADDR_CTRL, 32'h1, 33'h0);
    lo = 14'd100;
    hi = 14'd600;
    c10 = 1'b1;
    enc(14'd5);
    enc(14'd900);
    tx_run();
    close_out();
  end
endmodule : tb_gmpc_codec
